// ===== hw/drm_top.v
`timescale 1ns/1ps
`include "drm_regs.vh"
module drm_top #(
  parameter ANG_MAX = `DRM_ANG_MAX_CYC,
  parameter UPD_MIN = `DRM_UPD_CYC,
  parameter ZERO_CYC = `DRM_ZERO_CYC,
  parameter SAMPLE_MS = `DRM_UPD_MS
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire pulse0_i,
  input wire pulse1_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output wire irq_o
);
  reg [2:0] s0_reg;
  reg [2:0] s1_reg;
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s0_reg <= 3'b000;
      s1_reg <= 3'b000;
    end else begin
      s0_reg <= {s0_reg[1:0], pulse0_i};
      s1_reg <= {s1_reg[1:0], pulse1_i};
    end
  end
  wire [1:0] edge_w;
  assign edge_w[0] = s0_reg[1] & ~s0_reg[2];
  assign edge_w[1] = s1_reg[1] & ~s1_reg[2];

  // half a microsecond is 12.5 clocks: alternate 12 and 13, no drift
  reg [4:0] tick_cnt_reg;
  wire tick_w;
  assign tick_w = (tick_cnt_reg == `DRM_TICK_CYC - 1) ||
                  (tick_cnt_reg == `DRM_TICK_PAIR_CYC - 1);
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      tick_cnt_reg <= 5'h00;
    else if (tick_cnt_reg == `DRM_TICK_PAIR_CYC - 1)
      tick_cnt_reg <= 5'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 5'h01;
  end

  reg [3:0] ctrl_reg;
  reg [15:0] scale_reg;
  reg [15:0] sample_reg;
  reg [3:0] irq_en_reg;
  reg [3:0] irq_st_reg;
  wire [15:0] ratio_w [0:1];
  wire [15:0] angle_w [0:1];
  wire [1:0] done_w;
  wire [1:0] ang_ok_w;
  reg [1:0] rval_reg;
  reg [1:0] aval_reg;
  reg [31:0] freq_reg [0:1];
  reg [31:0] pcnt_reg [0:1];
  reg [24:0] win_reg;
  wire learn_freeze_w;
  wire res_coarse_w;
  // fast region forces coarse learning even with fine selected
  assign res_coarse_w = ~ctrl_reg[`DRM_CTRL_FINE] |
                        ctrl_reg[`DRM_CTRL_FAST];
  assign learn_freeze_w = ctrl_reg[`DRM_CTRL_LEARN] &
                          (scale_reg > 16'h0001);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      drm_chan #(
        .ANG_MAX(ANG_MAX),
        .UPD_MIN(UPD_MIN)
      ) u_chan (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick_w),
        .own_edge_i(edge_w[g]),
        .comp_edge_i(edge_w[1-g]),
        .ratio_o(ratio_w[g]),
        .angle_o(angle_w[g]),
        .done_o(done_w[g]),
        .ang_ok_o(ang_ok_w[g])
      );
    end
  endgenerate

  // f in pulses per 1000 s: count over 1.1 s gate times 1000/1.1
  function [31:0] drm_scale_freq;
    input [31:0] cnt;
    input coarse;
    reg [63:0] prod;
    reg [31:0] f;
    begin
      prod = {32'h00000000, cnt} * 64'h2710 / 64'hB;
      f = prod[31:0];
      if (f > `DRM_MAX_FREQ)
        f = `DRM_MAX_FREQ;
      if (coarse)
        f = f - (f % `DRM_MHZ_TEN);
      drm_scale_freq = f;
    end
  endfunction

  wire win_end_w;
  assign win_end_w = (win_reg >= ZERO_CYC - 1);
  integer k;
  integer j;
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_reg <= 25'h0000000;
      for (k = 0; k < 2; k = k + 1) begin
        pcnt_reg[k] <= 32'h00000000;
        freq_reg[k] <= 32'h00000000;
      end
    end else begin
      win_reg <= win_end_w ? 25'h0000000 : win_reg + 25'h0000001;
      for (k = 0; k < 2; k = k + 1) begin
        if (win_end_w) begin
          pcnt_reg[k] <= {31'h00000000, edge_w[k]};
          if (!learn_freeze_w) begin
            // below N pulses per window the lowest limit is passed
            if (pcnt_reg[k] < {16'h0000, scale_reg})
              freq_reg[k] <= 32'h00000000;
            else if (drm_scale_freq(pcnt_reg[k], 1'b0) < `DRM_MIN_FREQ)
              freq_reg[k] <= 32'h00000000;
            else
              freq_reg[k] <= drm_scale_freq(pcnt_reg[k],
                ctrl_reg[`DRM_CTRL_PAT]);
          end
        end else if (edge_w[k])
          pcnt_reg[k] <= pcnt_reg[k] + 32'h00000001;
      end
    end
  end

  wire [31:0] max_hz_w;
  // slow sampling lowers the supported input ceiling
  assign max_hz_w = (sample_reg >= `DRM_SAMPLE_SLOW_MS) ?
                    `DRM_MAX_HZ_SLOW : `DRM_MAX_FREQ / 1000;

  wire [3:0] ev_w;
  assign ev_w = {ang_ok_w[1] & done_w[1], done_w[1],
                 ang_ok_w[0] & done_w[0], done_w[0]};
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= 4'h0;
      scale_reg <= 16'h0001;
      sample_reg <= SAMPLE_MS[15:0];
      irq_en_reg <= 4'h0;
      irq_st_reg <= 4'h0;
      rval_reg <= 2'b00;
      aval_reg <= 2'b00;
    end else begin
      if (wr_i && addr_i == `DRM_A_CTRL)
        ctrl_reg <= wdata_i[3:0];
      if (wr_i && addr_i == `DRM_A_SCALE)
        scale_reg <= (wdata_i[15:0] == 16'h0000) ? 16'h0001 : wdata_i[15:0];
      if (wr_i && addr_i == `DRM_A_SAMPLE)
        sample_reg <= wdata_i[15:0];
      if (wr_i && addr_i == `DRM_A_IRQ_EN)
        irq_en_reg <= wdata_i[3:0];
      // set wins over clear
      irq_st_reg <= (irq_st_reg & ~((wr_i && addr_i == `DRM_A_IRQ_CLR) ?
                    wdata_i[3:0] : 4'h0)) | ev_w;
      for (j = 0; j < 2; j = j + 1) begin
        if (done_w[j]) begin
          rval_reg[j] <= 1'b1;
          aval_reg[j] <= ang_ok_w[j];
        end
      end
    end
  end
  assign irq_o = |(irq_st_reg & irq_en_reg);

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      rdata_o <= 32'h00000000;
    else if (rd_i) begin
      case (addr_i)
        `DRM_A_CTRL: rdata_o <= {27'h0000000, res_coarse_w, ctrl_reg};
        `DRM_A_STAT: rdata_o <= {28'h0000000, aval_reg[1], rval_reg[1],
                                 aval_reg[0], rval_reg[0]};
        `DRM_A_IRQ_EN: rdata_o <= {28'h0000000, irq_en_reg};
        `DRM_A_IRQ_CLR: rdata_o <= {28'h0000000, irq_st_reg};
        `DRM_A_RATIO0: rdata_o <= {16'h0000, ratio_w[0]};
        `DRM_A_ANGLE0: rdata_o <= {16'h0000, angle_w[0]};
        `DRM_A_RATIO1: rdata_o <= {16'h0000, ratio_w[1]};
        `DRM_A_ANGLE1: rdata_o <= {16'h0000, angle_w[1]};
        `DRM_A_FREQ0: rdata_o <= freq_reg[0];
        `DRM_A_FREQ1: rdata_o <= freq_reg[1];
        `DRM_A_SCALE: rdata_o <= {16'h0000, scale_reg};
        `DRM_A_SAMPLE: rdata_o <= {max_hz_w[15:0], sample_reg};
        default: rdata_o <= 32'h00000000;
      endcase
    end else
      rdata_o <= 32'h00000000;
  end
endmodule

// ===== inc/drm_regs.vh
`ifndef DRM_REGS_VH
`define DRM_REGS_VH
`define DRM_AW 4
`define DRM_A_CTRL 4'h0
`define DRM_A_STAT 4'h1
`define DRM_A_IRQ_EN 4'h2
`define DRM_A_IRQ_CLR 4'h3
`define DRM_A_RATIO0 4'h4
`define DRM_A_ANGLE0 4'h5
`define DRM_A_RATIO1 4'h6
`define DRM_A_ANGLE1 4'h7
`define DRM_A_FREQ0 4'h8
`define DRM_A_FREQ1 4'h9
`define DRM_A_SCALE 4'hA
`define DRM_A_SAMPLE 4'hB
`define DRM_CTRL_PAT 0
`define DRM_CTRL_LEARN 1
`define DRM_CTRL_FINE 2
`define DRM_CTRL_FAST 3
`define DRM_ST_RVAL 0
`define DRM_ST_AVAL 1
`define DRM_EV_RATIO 0
`define DRM_EV_ANGLE 1
`define DRM_RES_MAX 16'hFFFF
`define DRM_CLK_HZ 25000000
`define DRM_TICK_NS 500
`define DRM_TICK_CYC 12
`define DRM_TICK_PAIR_CYC 25
`define DRM_ANG_MIN_HZ 40
`define DRM_ANG_MAX_CYC 625000
`define DRM_UPD_MS 100
`define DRM_UPD_CYC 2500000
`define DRM_ZERO_MS 1100
`define DRM_ZERO_CYC 27500000
`define DRM_MIN_FREQ 950
`define DRM_MAX_FREQ 500000000
`define DRM_MAX_HZ_SLOW 200000
`define DRM_SAMPLE_SLOW_MS 200
`define DRM_MHZ_TEN 10
`endif

// ===== hw/drm_chan.v
`timescale 1ns/1ps
`include "drm_regs.vh"
module drm_chan #(
  parameter ANG_MAX = `DRM_ANG_MAX_CYC,
  parameter UPD_MIN = `DRM_UPD_CYC
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire tick_i,
  input wire own_edge_i,
  input wire comp_edge_i,
  output reg [15:0] ratio_o,
  output reg [15:0] angle_o,
  output reg done_o,
  output reg ang_ok_o
);
  reg [15:0] cnt_reg;
  reg [15:0] ang_reg;
  reg [23:0] cyc_reg;
  reg [23:0] gap_reg;
  reg [23:0] per_reg;
  reg seen_reg;
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 16'h0000;
      ang_reg <= 16'h0000;
      // no period known until two own pulses have been seen
      cyc_reg <= 24'hFFFFFF;
      gap_reg <= 24'h000000;
      per_reg <= 24'hFFFFFF;
      seen_reg <= 1'b0;
      ratio_o <= 16'h0000;
      angle_o <= `DRM_RES_MAX;
      done_o <= 1'b0;
      ang_ok_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (gap_reg != 24'hFFFFFF)
        gap_reg <= gap_reg + 24'h000001;
      if (cyc_reg != 24'hFFFFFF)
        cyc_reg <= cyc_reg + 24'h000001;
      if (own_edge_i) begin
        // wraps above 65535: user must keep ratio in range
        cnt_reg <= cnt_reg + 16'h0001;
        ang_reg <= 16'h0000;
        per_reg <= cyc_reg;
        cyc_reg <= 24'h000000;
        seen_reg <= 1'b1;
      end else if (tick_i && ang_reg != `DRM_RES_MAX)
        ang_reg <= ang_reg + 16'h0001;
      if (comp_edge_i) begin
        // rate limit: companion pulses inside 100 ms are merged
        if (gap_reg >= UPD_MIN[23:0]) begin
          ratio_o <= cnt_reg + {15'h0000, own_edge_i};
          done_o <= 1'b1;
          gap_reg <= 24'h000000;
          cnt_reg <= 16'h0000;
          if (seen_reg && per_reg < ANG_MAX[23:0]) begin
            angle_o <= own_edge_i ? 16'h0000 : ang_reg;
            ang_ok_o <= 1'b1;
          end else begin
            angle_o <= `DRM_RES_MAX;
            ang_ok_o <= 1'b0;
          end
        end
      end
      if (cyc_reg >= ANG_MAX[23:0] && !own_edge_i)
        per_reg <= 24'hFFFFFF;
    end
  end
endmodule

// ===== dv/drm_pulse_src.sv
`timescale 1ns/1ps
module drm_pulse_src (
  input wire core_clk_i,
  input wire [15:0] per0_i,
  input wire [15:0] per1_i,
  input wire [15:0] dly_i,
  output reg p0_o,
  output reg p1_o
);
  // shared time base keeps the two rates phase locked
  integer t = 0;
  // two-cycle pulses so the synchroniser never misses one
  // registered, so a rate change never glitches a pin mid-cycle
  always @(posedge core_clk_i) begin
    t <= t + 1;
    p0_o <= per0_i != 0 && t % per0_i < 2;
    p1_o <= per1_i != 0 && (t + per1_i - dly_i) % per1_i < 2;
  end
endmodule

// ===== dv/drm_top_asserts.sv
`timescale 1ns/1ps
`include "drm_regs.vh"
module drm_top_asserts #(
  parameter ZERO_CYC = `DRM_ZERO_CYC
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire pulse0_i,
  input wire pulse1_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire irq_o
);
  reg [3:0] ctrl_reg;
  integer pat_cnt;
  wire rd_freq = rd_i && addr_i[3:1] == 3'h4;
  wire rd_ratio = rd_i && addr_i[3:2] == 2'h1 && !addr_i[0];
  wire rd_angle = rd_i && addr_i[3:2] == 2'h1 && addr_i[0];
  // truncation is owed only after a whole window with pattern on
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= 4'h0;
      pat_cnt <= 0;
    end else if (wr_i && addr_i == `DRM_A_CTRL) begin
      ctrl_reg <= wdata_i[3:0];
      pat_cnt <= 0;
    end else if (ctrl_reg[0] && !ctrl_reg[1] && pat_cnt < ZERO_CYC + 4) begin
      pat_cnt <= pat_cnt + 1;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  chk_ratio_width:
    assert property (rd_ratio |=> rdata_o[31:16] == 16'h0)
    else $error("ratio read wider than 16 bits");
  chk_angle_width:
    assert property (rd_angle |=> rdata_o[31:16] == 16'h0)
    else $error("angle read wider than 16 bits");
  chk_freq_cap:
    assert property (rd_freq |=> rdata_o <= `DRM_MAX_FREQ)
    else $error("frequency above ceiling");
  chk_freq_floor:
    assert property (rd_freq ##1 rdata_o != 0 |-> rdata_o >= `DRM_MIN_FREQ)
    else $error("frequency below smallest value");
  chk_freq_trunc:
    assert property (rd_freq && pat_cnt == ZERO_CYC + 4 |=> rdata_o % 10 == 0)
    else $error("frequency not truncated");
  chk_coarse_learn:
    assert property (rd_i && addr_i == `DRM_A_CTRL |=>
      rdata_o[4:0] == {!ctrl_reg[2] || ctrl_reg[3], ctrl_reg})
    else $error("control readback wrong");
  chk_scale_nonzero:
    assert property (rd_i && addr_i == `DRM_A_SCALE |=> rdata_o[15:0] != 0)
    else $error("scaling factor reads zero");
  chk_irq_off:
    assert property (wr_i && addr_i == `DRM_A_IRQ_EN && wdata_i[3:0] == 4'h0
      |=> !irq_o)
    else $error("interrupt high with all enables off");
  cover property (rd_freq ##1 rdata_o != 0);
  cover property ($rose(irq_o));
  cover property (rd_freq && pat_cnt == ZERO_CYC + 4);
endmodule
bind drm_top drm_top_asserts #(.ZERO_CYC(ZERO_CYC)) i_drm_top_asserts (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pulse0_i(pulse0_i),
  .pulse1_i(pulse1_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ===== dv/test_dual_channel_ratio_angle_meter.sv
`timescale 1ns/1ps
`include "drm_regs.vh"
module test_dual_channel_ratio_angle_meter;
  reg core_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [15:0] per0 = 16'h0;
  reg [15:0] per1 = 16'h0;
  reg [15:0] dly = 16'h1E;
  reg [31:0] rv;
  reg [31:0] keep;
  wire pulse0_i;
  wire pulse1_i;
  wire [31:0] rdata_o;
  wire irq_o;
  integer n_errors = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer i;
  always #20 core_clk_i = ~core_clk_i;
  // short counts keep the run near 55k cycles
  drm_top #(.ANG_MAX(2000), .UPD_MIN(100), .ZERO_CYC(5000)) i_drm_top (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pulse0_i(pulse0_i),
    .pulse1_i(pulse1_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  drm_pulse_src i_drm_pulse_src (.core_clk_i(core_clk_i), .per0_i(per0),
    .per1_i(per1), .dly_i(dly), .p0_o(pulse0_i), .p1_o(pulse1_i));
  task results;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  task ceq(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task crng(input [31:0] g, input [31:0] lo, input [31:0] hi);
    begin
      comparisons = comparisons + 1;
      if ((g >= lo && g <= hi) !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h range %h %h", $time, g, lo, hi);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      rv = rdata_o;
    end
  endtask
  task rchk(input [3:0] a, input [31:0] e);
    begin
      rd(a);
      ceq(rv, e);
    end
  endtask
  task t_reset;
    begin
      rchk(`DRM_A_CTRL, 32'h10);
      rchk(`DRM_A_SCALE, 32'h1);
      rchk(`DRM_A_SAMPLE, 32'hA1200064);
      rchk(`DRM_A_ANGLE0, 32'hFFFF);
      rchk(`DRM_A_FREQ0, 32'h0);
      rchk(`DRM_A_STAT, 32'h0);
      rchk(4'hF, 32'h0);
      $display("test reset done");
    end
  endtask
  task t_ratio;
    begin
      per0 <= 16'h32;
      per1 <= 16'h258;
      repeat (3000) @(posedge core_clk_i);
      rchk(`DRM_A_RATIO0, 32'hC);
      rd(`DRM_A_ANGLE0);
      crng(rv, 32'h2, 32'h3);
      rd(`DRM_A_STAT);
      ceq(rv & 32'h3, 32'h3);
      // companion faster than the update limit: every second edge counts
      per0 <= 16'h14;
      per1 <= 16'h3C;
      repeat (1000) @(posedge core_clk_i);
      rchk(`DRM_A_RATIO0, 32'h6);
      per0 <= 16'h9C4;
      per1 <= 16'h9C4;
      repeat (10000) @(posedge core_clk_i);
      rchk(`DRM_A_ANGLE0, 32'hFFFF);
      rchk(`DRM_A_RATIO0, 32'h1);
      rchk(`DRM_A_RATIO1, 32'h1);
      rchk(`DRM_A_ANGLE1, 32'hFFFF);
      rchk(`DRM_A_STAT, 32'h5);
      $display("test ratio done");
    end
  endtask
  task t_irq;
    begin
      wr(`DRM_A_IRQ_CLR, 32'hF);
      wr(`DRM_A_IRQ_EN, 32'h1);
      per0 <= 16'h32;
      per1 <= 16'h258;
      i = 0;
      while (irq_o !== 1'b1 && i < 2000) begin
        @(posedge core_clk_i);
        i = i + 1;
      end
      ceq({31'h0, irq_o}, 32'h1);
      rd(`DRM_A_IRQ_CLR);
      ceq(rv & 32'h1, 32'h1);
      wr(`DRM_A_IRQ_EN, 32'h0);
      @(negedge core_clk_i);
      ceq({31'h0, irq_o}, 32'h0);
      per0 <= 16'h0;
      per1 <= 16'h0;
      repeat (20) @(posedge core_clk_i);
      wr(`DRM_A_IRQ_CLR, 32'hF);
      wr(`DRM_A_IRQ_EN, 32'hF);
      @(negedge core_clk_i);
      ceq({31'h0, irq_o}, 32'h0);
      rchk(`DRM_A_IRQ_CLR, 32'h0);
      $display("test irq done");
    end
  endtask
  task t_freq;
    begin
      per0 <= 16'h32;
      repeat (10010) @(posedge core_clk_i);
      rd(`DRM_A_FREQ0);
      crng(rv, 32'h15F90, 32'h166AA);
      wr(`DRM_A_CTRL, 32'h1);
      repeat (10010) @(posedge core_clk_i);
      rd(`DRM_A_FREQ0);
      ceq(rv % 32'hA, 32'h0);
      wr(`DRM_A_SCALE, 32'h2);
      wr(`DRM_A_CTRL, 32'h2);
      rd(`DRM_A_FREQ0);
      keep = rv;
      per0 <= 16'h19;
      repeat (10010) @(posedge core_clk_i);
      rchk(`DRM_A_FREQ0, keep);
      wr(`DRM_A_CTRL, 32'h0);
      per0 <= 16'h0;
      repeat (10010) @(posedge core_clk_i);
      rchk(`DRM_A_FREQ0, 32'h0);
      wr(`DRM_A_SCALE, 32'h0);
      rchk(`DRM_A_SCALE, 32'h1);
      wr(`DRM_A_SAMPLE, 32'hC8);
      rchk(`DRM_A_SAMPLE, 32'h0D4000C8);
      wr(`DRM_A_CTRL, 32'h4);
      rchk(`DRM_A_CTRL, 32'h4);
      wr(`DRM_A_CTRL, 32'hC);
      rchk(`DRM_A_CTRL, 32'h1C);
      $display("test freq done");
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_ratio;
    t_irq;
    t_freq;
    results;
  end
endmodule
